// File: verilog/dma_defines.vh
/*
 * constants of the dac mode-control register block: register indices,
 * field positions, reset values and timing counts.
 * assumes inclusion by bare name from the design files.
 */
// Contract
// RL1 - attenuation is half a decibel times code minus 255, top code 0 dB
// RL2 - codes 0 through 128 mean full mute of the channel
// RL3 - both attenuation codes reset to 255, no attenuation
// RL4 - one shared load enable; attenuation writes accepted only while it is one
// RL5 - load enable resets to zero; clearing it discards held attenuation data
// RL6 - host should set load enable right after every reset
// RL7 - soft mute set ramps level down one step per interval to mute
// RL8 - soft mute cleared ramps level back up to the programmed code
// RL9 - ramp step interval is two samples, or four when rate select is one
// RL10 - zero-detect mute enable, reset off, never touches the zero flags
// RL11 - oversampling select: 64x when zero, 128x when one
// RL12 - host keeps 64x whenever sample rate exceeds 96 kHz
// RL13 - output disable resets zero; when one, channel holds bipolar zero
// RL14 - de-emphasis enable, one on, zero off, reset zero
// RL15 - de-emphasis rate 00 44.1k, 01 48k, 10 32k, 11 reserved
// RL16 - format 000..011 right-justified 24, 20, 18, 16 bits
// RL17 - format 100 i2s, 101 justified 16-24 bits, 110 and 111 reserved
// RL18 - control word top bit: zero writes, one reads
// RL19 - channel zero-detected after 1024 consecutive zero samples, channels independent
// RL20 - zero-detect mute forces a zero-detected channel to bipolar zero at once
// RL21 - reserved bits read zero; reserved field codes stored but act as reset
`ifndef DMA_DEFINES_VH
`define DMA_DEFINES_VH

`define DMA_IDX_ATT_L       7'h10
`define DMA_IDX_ATT_R       7'h11
`define DMA_IDX_MODE        7'h12
`define DMA_IDX_DEEMPH      7'h13
`define DMA_IDX_FORMAT      7'h14

`define DMA_WORD_BITS       5'h10
`define DMA_HDR_BITS        5'h08

`define DMA_MODE_MUTE_L     0
`define DMA_MODE_MUTE_R     1
`define DMA_MODE_RATE       2
`define DMA_MODE_LOAD       3
`define DMA_MODE_ZDMUTE     4
`define DMA_MODE_OVS        6
`define DMA_DE_DIS_L        0
`define DMA_DE_DIS_R        1
`define DMA_DE_EN           4
`define DMA_DE_RATE_LO      5

`define DMA_ATT_RESET       8'hff
`define DMA_ATT_MUTE        8'h80
`define DMA_DEEMPH_RSVD     2'h3
`define DMA_FMT_RESET       3'h0
`define DMA_FMT_LAST_VALID  3'h5

`define DMA_RAMP_SLOW       2'h3
`define DMA_RAMP_FAST       2'h1
`define DMA_ZERO_RUN        11'h400

`endif

// File: verilog/dma_att_ramp.v
/*
 * one channel's attenuator ramp: moves the live level one step per
 * interval toward the programmed code or toward mute.
 * assumes a one-cycle sample tick from the sample-rate clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dma_defines.vh"

module dma_att_ramp (
	input  wire       i_sys_clk,
	input  wire       i_sys_rst,
	input  wire       i_sample_tick,
	input  wire       i_rate_sel,
	input  wire       i_soft_mute,
	input  wire [7:0] i_code,
	output reg  [7:0] o_level_ff
);

	reg  [1:0] tick_cnt_ff;
	wire [7:0] tgt;
	wire       step;

	// codes at or below the mute code all collapse onto it
	assign tgt  = (i_soft_mute || i_code <= `DMA_ATT_MUTE) ? `DMA_ATT_MUTE : i_code; // RL2 RL7 RL8
	assign step = i_sample_tick &&
		(tick_cnt_ff == (i_rate_sel ? `DMA_RAMP_SLOW : `DMA_RAMP_FAST)); // RL9

	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			tick_cnt_ff <= 2'h0;
			o_level_ff  <= `DMA_ATT_RESET; // RL3
		end else begin
			if (step)
				tick_cnt_ff <= 2'h0;
			else if (i_sample_tick)
				tick_cnt_ff <= tick_cnt_ff + 2'h1;
			if (step && o_level_ff > tgt)
				o_level_ff <= o_level_ff - 8'h01; // RL7 RL9
			else if (step && o_level_ff < tgt)
				o_level_ff <= o_level_ff + 8'h01; // RL8 RL9
		end
	end

endmodule // dma_att_ramp
`default_nettype wire

// File: verilog/dma_zero_det.v
/*
 * one channel's zero detector: counts consecutive all-zero samples.
 * assumes the zero indication is valid on the sample tick.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dma_defines.vh"

module dma_zero_det (
	input  wire i_sys_clk,
	input  wire i_sys_rst,
	input  wire i_sample_tick,
	input  wire i_sample_zero,
	output reg  o_zero_ff
);

	reg [10:0] run_ff;

	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			run_ff    <= 11'h000;
			o_zero_ff <= 1'b0;
		end else if (i_sample_tick) begin
			if (!i_sample_zero) begin
				run_ff    <= 11'h000;
				o_zero_ff <= 1'b0;
			end else if (run_ff != `DMA_ZERO_RUN) begin
				run_ff    <= run_ff + 11'h001;
				o_zero_ff <= (run_ff + 11'h001) == `DMA_ZERO_RUN; // RL19
			end
		end
	end

endmodule // dma_zero_det
`default_nettype wire

// File: verilog/dma_mode_ctrl.v
/*
 * mode-control register bank of a stereo audio dac: serial control port,
 * attenuation with soft-mute ramping, zero detect, output and format controls.
 * assumes control and sample-rate clock pins are asynchronous to i_sys_clk,
 * and per-sample zero indications come from same-clock audio logic.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dma_defines.vh"

module dma_mode_ctrl (
	input  wire       i_sys_clk,
	input  wire       i_sys_rst,
	input  wire       i_ctl_latch,
	input  wire       i_ctl_clk,
	input  wire       i_ctl_data,
	output reg        o_ctl_data_ff,
	input  wire       i_lrck,
	input  wire       i_left_sample_zero,
	input  wire       i_right_sample_zero,
	output reg  [7:0] o_left_level_ff,
	output reg  [7:0] o_right_level_ff,
	output reg        o_left_output_bpz_ff,
	output reg        o_right_output_bpz_ff,
	output reg        o_left_zero_flag_ff,
	output reg        o_right_zero_flag_ff,
	output reg        o_ovs_128_ff,
	output reg        o_deemph_enable_ff,
	output reg  [1:0] o_deemph_rate_ff,
	output reg  [2:0] o_audio_format_ff
);

	// pin synchronisers: stage 1, stage 2, previous; the data pin has stage 1 and stage 2 only
	reg  [2:0] latch_sy_ff;
	reg  [2:0] cclk_sy_ff;
	reg  [1:0] cdat_sy_ff;
	reg  [2:0] lrck_sy_ff;

	reg  [4:0]  bit_cnt_ff;
	reg  [15:0] shift_ff;
	reg  [7:0]  rd_sh_ff;
	reg         rd_mode_ff;

	reg  [7:0] left_code_ff;
	reg  [7:0] right_code_ff;
	reg  [7:0] mode_reg_ff;
	reg  [7:0] deemph_reg_ff;
	reg  [2:0] format_ff;

	wire       cclk_rise;
	wire       cclk_fall;
	wire       frame_end;
	wire       sample_tick;
	wire       load_en;
	wire [7:0] left_level;
	wire [7:0] right_level;
	wire       left_zero;
	wire       right_zero;
	wire [15:0] nxt_shift;

	function [7:0] reg_read;
		input [6:0] idx;
		begin
			case (idx)
			`DMA_IDX_ATT_L:  reg_read = left_code_ff;
			`DMA_IDX_ATT_R:  reg_read = right_code_ff;
			`DMA_IDX_MODE:   reg_read = mode_reg_ff;
			`DMA_IDX_DEEMPH: reg_read = deemph_reg_ff;
			`DMA_IDX_FORMAT: reg_read = {5'h00, format_ff};
			default:         reg_read = 8'h00;
			endcase
		end
	endfunction

	assign cclk_rise   = cclk_sy_ff[1] && !cclk_sy_ff[2] && !latch_sy_ff[1];
	assign cclk_fall   = !cclk_sy_ff[1] && cclk_sy_ff[2] && !latch_sy_ff[1];
	assign frame_end   = latch_sy_ff[1] && !latch_sy_ff[2];
	assign sample_tick = lrck_sy_ff[1] && !lrck_sy_ff[2];
	assign load_en     = mode_reg_ff[`DMA_MODE_LOAD];
	assign nxt_shift   = {shift_ff[14:0], cdat_sy_ff[1]};

	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			latch_sy_ff <= 3'h7;
			cclk_sy_ff  <= 3'h0;
			cdat_sy_ff  <= 2'h0;
			lrck_sy_ff  <= 3'h0;
		end else begin
			latch_sy_ff <= {latch_sy_ff[1:0], i_ctl_latch};
			cclk_sy_ff  <= {cclk_sy_ff[1:0], i_ctl_clk};
			cdat_sy_ff  <= {cdat_sy_ff[0], i_ctl_data};
			lrck_sy_ff  <= {lrck_sy_ff[1:0], i_lrck};
		end
	end

	// control word shifter, msb first, framed by the latch pin low
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			bit_cnt_ff    <= 5'h00;
			shift_ff      <= 16'h0000;
			rd_sh_ff      <= 8'h00;
			rd_mode_ff    <= 1'b0;
			o_ctl_data_ff <= 1'b0;
		end else if (latch_sy_ff[1]) begin
			bit_cnt_ff    <= 5'h00;
			o_ctl_data_ff <= 1'b0;
		end else begin
			if (cclk_rise && bit_cnt_ff != `DMA_WORD_BITS) begin
				shift_ff   <= nxt_shift;
				bit_cnt_ff <= bit_cnt_ff + 5'h01;
				if (bit_cnt_ff == `DMA_HDR_BITS - 5'h01) begin
					rd_sh_ff   <= reg_read(nxt_shift[6:0]);
					rd_mode_ff <= nxt_shift[7]; // RL18
				end
			end
			// read data goes out on falling edges after the header;
			// read bit held apart, the shifter moves it on during data
			if (cclk_fall && rd_mode_ff && bit_cnt_ff >= `DMA_HDR_BITS &&
				bit_cnt_ff < `DMA_WORD_BITS) begin // RL18
				o_ctl_data_ff <= rd_sh_ff[7];
				rd_sh_ff      <= {rd_sh_ff[6:0], 1'b0};
			end
		end
	end

	// register writes on latch rising after a full write word
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			left_code_ff  <= `DMA_ATT_RESET; // RL3
			right_code_ff <= `DMA_ATT_RESET; // RL3
			mode_reg_ff   <= 8'h00; // RL5 RL10 RL11
			deemph_reg_ff <= 8'h00; // RL13 RL14 RL15
			format_ff     <= `DMA_FMT_RESET; // RL16
		end else begin
			if (frame_end && bit_cnt_ff == `DMA_WORD_BITS && !shift_ff[15]) begin // RL18
				case (shift_ff[14:8])
				`DMA_IDX_ATT_L:
					if (load_en)
						left_code_ff <= shift_ff[7:0]; // RL4
				`DMA_IDX_ATT_R:
					if (load_en)
						right_code_ff <= shift_ff[7:0]; // RL4
				`DMA_IDX_MODE:   mode_reg_ff <= shift_ff[7:0] & 8'h5f; // RL21
				`DMA_IDX_DEEMPH: deemph_reg_ff <= shift_ff[7:0] & 8'h73; // RL21
				`DMA_IDX_FORMAT: format_ff <= shift_ff[2:0];
				default: ;
				endcase
			end
			if (!load_en) begin
				left_code_ff  <= `DMA_ATT_RESET; // RL5
				right_code_ff <= `DMA_ATT_RESET; // RL5
			end
		end
	end

	dma_att_ramp u_left_ramp (
		.i_sys_clk     (i_sys_clk),
		.i_sys_rst     (i_sys_rst),
		.i_sample_tick (sample_tick),
		.i_rate_sel    (mode_reg_ff[`DMA_MODE_RATE]),
		.i_soft_mute   (mode_reg_ff[`DMA_MODE_MUTE_L]),
		.i_code        (left_code_ff),
		.o_level_ff    (left_level)
	);

	dma_att_ramp u_right_ramp (
		.i_sys_clk     (i_sys_clk),
		.i_sys_rst     (i_sys_rst),
		.i_sample_tick (sample_tick),
		.i_rate_sel    (mode_reg_ff[`DMA_MODE_RATE]),
		.i_soft_mute   (mode_reg_ff[`DMA_MODE_MUTE_R]),
		.i_code        (right_code_ff),
		.o_level_ff    (right_level)
	);

	dma_zero_det u_left_zero (
		.i_sys_clk     (i_sys_clk),
		.i_sys_rst     (i_sys_rst),
		.i_sample_tick (sample_tick),
		.i_sample_zero (i_left_sample_zero),
		.o_zero_ff     (left_zero)
	);

	dma_zero_det u_right_zero (
		.i_sys_clk     (i_sys_clk),
		.i_sys_rst     (i_sys_rst),
		.i_sample_tick (sample_tick),
		.i_sample_zero (i_right_sample_zero),
		.o_zero_ff     (right_zero)
	);

	// output stage, all registered
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_left_level_ff       <= `DMA_ATT_RESET;
			o_right_level_ff      <= `DMA_ATT_RESET;
			o_left_output_bpz_ff  <= 1'b0;
			o_right_output_bpz_ff <= 1'b0;
			o_left_zero_flag_ff   <= 1'b0;
			o_right_zero_flag_ff  <= 1'b0;
			o_ovs_128_ff          <= 1'b0;
			o_deemph_enable_ff    <= 1'b0;
			o_deemph_rate_ff      <= 2'h0;
			o_audio_format_ff     <= `DMA_FMT_RESET;
		end else begin
			o_left_level_ff  <= left_level; // RL1
			o_right_level_ff <= right_level; // RL1
			o_left_output_bpz_ff <= deemph_reg_ff[`DMA_DE_DIS_L] || // RL13
				left_level <= `DMA_ATT_MUTE || // RL2
				(mode_reg_ff[`DMA_MODE_ZDMUTE] && left_zero); // RL20
			o_right_output_bpz_ff <= deemph_reg_ff[`DMA_DE_DIS_R] || // RL13
				right_level <= `DMA_ATT_MUTE || // RL2
				(mode_reg_ff[`DMA_MODE_ZDMUTE] && right_zero); // RL20
			o_left_zero_flag_ff  <= left_zero; // RL10
			o_right_zero_flag_ff <= right_zero; // RL10
			o_ovs_128_ff         <= mode_reg_ff[`DMA_MODE_OVS]; // RL11
			o_deemph_enable_ff   <= deemph_reg_ff[`DMA_DE_EN]; // RL14
			if (deemph_reg_ff[`DMA_DE_RATE_LO+1:`DMA_DE_RATE_LO] == `DMA_DEEMPH_RSVD)
				o_deemph_rate_ff <= 2'h0; // RL21
			else
				o_deemph_rate_ff <= deemph_reg_ff[`DMA_DE_RATE_LO+1:`DMA_DE_RATE_LO]; // RL15
			if (format_ff > `DMA_FMT_LAST_VALID)
				o_audio_format_ff <= `DMA_FMT_RESET; // RL21
			else
				o_audio_format_ff <= format_ff; // RL16 RL17
		end
	end

endmodule // dma_mode_ctrl
`default_nettype wire

// File: dv/dma_mode_ctrl_sva.sv
/* checker for the dac mode-control block: reset, ramp and field relations.
   assumes the bench runs lrck at eight system clocks a sample. */
`timescale 1ns/1ps
`default_nettype none
module dma_mode_ctrl_sva (
	input wire logic       i_sys_clk,
	input wire logic       i_sys_rst,
	input wire logic       i_ctl_latch,
	input wire logic       i_left_sample_zero,
	input wire logic       o_ctl_data_ff,
	input wire logic [7:0] o_left_level_ff,
	input wire logic [7:0] o_right_level_ff,
	input wire logic       o_left_output_bpz_ff,
	input wire logic       o_left_zero_flag_ff,
	input wire logic       o_ovs_128_ff,
	input wire logic       o_deemph_enable_ff,
	input wire logic [1:0] o_deemph_rate_ff,
	input wire logic [2:0] o_audio_format_ff
);
	logic [13:0] zrun_ff;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	// cycles the left zero indication has stayed high
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst || !i_left_sample_zero)
			zrun_ff <= 14'h0;
		else if (zrun_ff != 14'h3fff)
			zrun_ff <= zrun_ff + 14'h1;
	end
	rst_levels_a: assert property (disable iff (1'b0) i_sys_rst |=>
		o_left_level_ff == 8'hff && o_right_level_ff == 8'hff) else $error("levels not ff after reset");
	rst_modes_a: assert property (disable iff (1'b0) i_sys_rst |=> !o_ovs_128_ff &&
		!o_deemph_enable_ff && o_deemph_rate_ff == 2'h0 && o_audio_format_ff == 3'h0)
		else $error("mode outputs not cleared by reset");
	step_size_a: assert property (!$stable(o_left_level_ff) |->
		o_left_level_ff == $past(o_left_level_ff) + 8'h1 ||
		o_left_level_ff == $past(o_left_level_ff) - 8'h1) else $error("level moved more than one step");
	step_gap_a: assert property (!$stable(o_left_level_ff) |=>
		$stable(o_left_level_ff)[*8]) else $error("level steps too close together");
	mute_bpz_a: assert property ((o_left_level_ff <= 8'h80)[*2] |->
		o_left_output_bpz_ff) else $error("muted level not at bipolar zero");
	zero_run_a: assert property ($rose(o_left_zero_flag_ff) |->
		zrun_ff >= 14'h1fa4) else $error("zero flag set too early");
	read_idle_a: assert property (i_ctl_latch[*6] |-> !o_ctl_data_ff)
		else $error("read data not low outside frame");
	rsvd_codes_a: assert property (o_deemph_rate_ff != 2'h3 &&
		o_audio_format_ff <= 3'h5) else $error("reserved code reached an output");
endmodule // dma_mode_ctrl_sva
bind dma_mode_ctrl dma_mode_ctrl_sva i_sva (
	.i_sys_clk            (i_sys_clk),
	.i_sys_rst            (i_sys_rst),
	.i_ctl_latch          (i_ctl_latch),
	.i_left_sample_zero   (i_left_sample_zero),
	.o_ctl_data_ff        (o_ctl_data_ff),
	.o_left_level_ff      (o_left_level_ff),
	.o_right_level_ff     (o_right_level_ff),
	.o_left_output_bpz_ff (o_left_output_bpz_ff),
	.o_left_zero_flag_ff  (o_left_zero_flag_ff),
	.o_ovs_128_ff         (o_ovs_128_ff),
	.o_deemph_enable_ff   (o_deemph_enable_ff),
	.o_deemph_rate_ff     (o_deemph_rate_ff),
	.o_audio_format_ff    (o_audio_format_ff)
);
`default_nettype wire

// File: dv/dma_host.sv
/* host controller model for the serial control port.
   assumes the device takes bits on rising shift clock edges. */
`timescale 1ns/1ps
`default_nettype none
module dma_host (
	input  wire logic i_sys_clk,
	input  wire logic i_ctl_data,
	output var  logic o_ctl_latch,
	output var  logic o_ctl_clk,
	output var  logic o_ctl_data
);
	initial begin
		o_ctl_latch = 1'b1;
		o_ctl_clk = 1'b0;
		o_ctl_data = 1'b0;
	end
	task automatic half();
		repeat (5) @(negedge i_sys_clk);
	endtask
	// msb first; last eight samples are the read byte
	task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rdat);
		rdat = 8'h00;
		o_ctl_latch = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			o_ctl_data = word[15 - i];
			half();
			rdat = {rdat[6:0], i_ctl_data};
			o_ctl_clk = 1'b1;
			half();
			o_ctl_clk = 1'b0;
		end
		half();
		o_ctl_latch = 1'b1;
		o_ctl_data = ~o_ctl_data;
		repeat (8) @(negedge i_sys_clk);
	endtask
endmodule // dma_host
`default_nettype wire

// File: dv/dma_mode_ctrl_tb_top.sv
/* bench for the dac mode-control block: registers, ramps, fields, zero detect.
   assumes the host model drives the control port. */
`timescale 1ns/1ps
`default_nettype none
`include "dma_defines.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
	$display("FAIL %0t got %h exp %h", $time, a, b); end end
module dma_mode_ctrl_tb_top;
	logic i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_lrck = 1'b0;
	logic i_left_sample_zero = 1'b0, i_right_sample_zero = 1'b0;
	wire logic [7:0] o_left_level_ff, o_right_level_ff;
	wire logic [2:0] o_audio_format_ff;
	wire logic [1:0] o_deemph_rate_ff;
	wire logic i_ctl_latch, i_ctl_clk, i_ctl_data, o_ctl_data_ff, o_ovs_128_ff;
	wire logic o_left_output_bpz_ff, o_right_output_bpz_ff, o_deemph_enable_ff;
	wire logic o_left_zero_flag_ff, o_right_zero_flag_ff;
	int mismatches = 0, compares = 0, cycles = 0, gap;
	logic [7:0] r;
	// sample clock stopped while 128x oversampling is on
	logic lrck_hold = 1'b0;
	always #50 i_sys_clk = ~i_sys_clk;
	initial #100 forever #400 i_lrck = lrck_hold ? i_lrck : ~i_lrck;
	dma_mode_ctrl i_dut (
		.i_sys_clk             (i_sys_clk),
		.i_sys_rst             (i_sys_rst),
		.i_ctl_latch           (i_ctl_latch),
		.i_ctl_clk             (i_ctl_clk),
		.i_ctl_data            (i_ctl_data),
		.o_ctl_data_ff         (o_ctl_data_ff),
		.i_lrck                (i_lrck),
		.i_left_sample_zero    (i_left_sample_zero),
		.i_right_sample_zero   (i_right_sample_zero),
		.o_left_level_ff       (o_left_level_ff),
		.o_right_level_ff      (o_right_level_ff),
		.o_left_output_bpz_ff  (o_left_output_bpz_ff),
		.o_right_output_bpz_ff (o_right_output_bpz_ff),
		.o_left_zero_flag_ff   (o_left_zero_flag_ff),
		.o_right_zero_flag_ff  (o_right_zero_flag_ff),
		.o_ovs_128_ff          (o_ovs_128_ff),
		.o_deemph_enable_ff    (o_deemph_enable_ff),
		.o_deemph_rate_ff      (o_deemph_rate_ff),
		.o_audio_format_ff     (o_audio_format_ff)
	);
	dma_host i_host (.i_sys_clk(i_sys_clk), .i_ctl_data(o_ctl_data_ff),
		.o_ctl_latch(i_ctl_latch), .o_ctl_clk(i_ctl_clk), .o_ctl_data(i_ctl_data));
	task automatic wr(input logic [6:0] idx, input logic [7:0] d);
		i_host.xfer({1'b0, idx, d}, 16, r);
	endtask
	task automatic rc(input logic [6:0] idx, input logic [7:0] e);
		i_host.xfer({1'b1, idx, 8'h00}, 16, r);
		`CHK(r, e)
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			stop_test();
		end
	end
	initial begin
		wt(12);
		i_sys_rst = 1'b0;
		wt(4);
		`CHK(o_left_level_ff, 8'hff)
		rc(`DMA_IDX_ATT_R, 8'hff);
		rc(`DMA_IDX_MODE, 8'h00);
		rc(`DMA_IDX_DEEMPH, 8'h00);
		rc(`DMA_IDX_FORMAT, 8'h00);
		wr(`DMA_IDX_ATT_L, 8'h90);
		rc(`DMA_IDX_ATT_L, 8'hff);
		$display("test reset done");
		wr(`DMA_IDX_MODE, 8'h08);
		wr(`DMA_IDX_ATT_L, 8'h84);
		wr(`DMA_IDX_ATT_R, 8'h90);
		wt(2300);
		`CHK(o_left_level_ff, 8'h84)
		`CHK(o_right_level_ff, 8'h90)
		for (int k = 0; k < 2; k++) begin
			wr(`DMA_IDX_MODE, {5'h01, k[0], 2'h0});
			wr(`DMA_IDX_ATT_L, k ? 8'h84 : 8'h90);
			@(o_left_level_ff);
			@(negedge i_sys_clk);
			r = o_left_level_ff;
			gap = 0;
			while (o_left_level_ff === r) begin
				@(negedge i_sys_clk);
				gap++;
			end
			`CHK(gap, 16 << k)
		end
		wt(800);
		wr(`DMA_IDX_MODE, 8'h09);
		wt(300);
		`CHK(o_left_level_ff, 8'h80)
		`CHK(o_left_output_bpz_ff, 1'b1)
		`CHK(o_right_level_ff, 8'h90)
		wr(`DMA_IDX_MODE, 8'h08);
		wt(300);
		`CHK(o_left_level_ff, 8'h84)
		`CHK(o_left_output_bpz_ff, 1'b0)
		$display("test ramp done");
		lrck_hold = 1'b1;
		wr(`DMA_IDX_MODE, 8'hff);
		rc(`DMA_IDX_MODE, 8'h5f);
		`CHK(o_ovs_128_ff, 1'b1)
		wr(`DMA_IDX_MODE, 8'h00);
		lrck_hold = 1'b0;
		rc(`DMA_IDX_ATT_L, 8'hff);
		for (int k = 0; k < 4; k++) begin
			wr(`DMA_IDX_DEEMPH, {1'b1, k[1:0], 5'h11});
			`CHK(o_deemph_rate_ff, (k == 3) ? 2'h0 : k[1:0])
			`CHK(o_deemph_enable_ff, 1'b1)
			`CHK(o_left_output_bpz_ff, 1'b1)
			rc(`DMA_IDX_DEEMPH, {1'b0, k[1:0], 5'h11});
		end
		wr(`DMA_IDX_DEEMPH, 8'h00);
		for (int k = 0; k < 8; k++) begin
			wr(`DMA_IDX_FORMAT, {5'h1f, k[2:0]});
			`CHK(o_audio_format_ff, (k > 5) ? 3'h0 : k[2:0])
			rc(`DMA_IDX_FORMAT, {5'h00, k[2:0]});
		end
		i_host.xfer({1'b0, `DMA_IDX_FORMAT, 8'h01}, 12, r);
		rc(`DMA_IDX_FORMAT, 8'h07);
		rc(7'h20, 8'h00);
		$display("test fields done");
		wr(`DMA_IDX_MODE, 8'h10);
		i_left_sample_zero = 1'b1;
		wt(8000);
		`CHK(o_left_zero_flag_ff, 1'b0)
		wt(400);
		`CHK(o_left_zero_flag_ff, 1'b1)
		`CHK(o_right_zero_flag_ff, 1'b0)
		`CHK(o_left_output_bpz_ff, 1'b1)
		`CHK(o_right_output_bpz_ff, 1'b0)
		wr(`DMA_IDX_MODE, 8'h00);
		`CHK(o_left_zero_flag_ff, 1'b1)
		`CHK(o_left_output_bpz_ff, 1'b0)
		i_left_sample_zero = 1'b0;
		wt(30);
		`CHK(o_left_zero_flag_ff, 1'b0)
		$display("test zero detect done");
		stop_test();
	end
endmodule // dma_mode_ctrl_tb_top
`default_nettype wire
